/* verilog/ext_irq_pkg.sv */
/*
 Constants for the two external pin interrupt sources: the pin configuration
 register, its field positions and reset value, and the pending flag positions
 in the timer control register.
 Assumes an SFR-style register port with an 8-bit address and 8-bit data.
*/
package ext_irq_pkg;
   localparam logic [7:0] pin_config_addr = 8'he4;
   localparam logic [7:0] pin_config_reset = 8'h01;
   localparam int b_polarity_bit = 7;
   localparam int b_select_lsb = 4;
   localparam int a_polarity_bit = 3;
   localparam int a_select_lsb = 0;
   localparam int select_width = 3;
   localparam int a_trigger_bit = 0;
   localparam int a_pending_bit = 1;
   localparam int b_trigger_bit = 2;
   localparam int b_pending_bit = 3;
   localparam logic trigger_level = 1'b0;
   localparam logic trigger_edge = 1'b1;
endpackage

/* verilog/ext_irq_channel.sv */
/*
 One external interrupt channel: pin select, two-flop synchroniser, polarity
 and edge or level detection, and the pending flag.
 Assumes port pins synchronous or slow; the pin is only read, never driven.
*/
`timescale 1ns/1ps
module ext_irq_channel #(
   parameter int pins = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [pins-1:0] port_pins,
   input wire logic [2:0] pin_select,
   input wire logic polarity,
   input wire logic trigger_type,
   input wire logic vector_ack,
   input wire logic flag_write,
   input wire logic flag_value,
   output logic pending
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic flag;
   } chan_state_t;

   chan_state_t s_q;
   chan_state_t s_d;
   logic active_now;
   logic active_prev;
   logic rise;

   always_comb
   begin
      s_d = s_q;
      s_d.sync1 = port_pins[pin_select];
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
      active_now = s_q.sync2 ~^ polarity;
      active_prev = s_q.prev ~^ polarity;
      rise = active_now && !active_prev;
      if (trigger_type == ext_irq_pkg::trigger_edge)
      begin
         if (rise)
            s_d.flag = 1'b1;
         else if (vector_ack || flag_write)
            s_d.flag = vector_ack ? 1'b0 : flag_value;
      end
      else
         s_d.flag = active_now;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      // Sample flops start at the idle-high pin level, so no false request follows reset
      if (!rst_b)
         s_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, flag: 1'b0};
      else
         s_q <= s_d;
   end

   assign pending = s_q.flag;

   a_level_tracks: assert property (@(posedge clk) disable iff (!rst_b)
      (trigger_type == ext_irq_pkg::trigger_level && $stable(trigger_type))
      |=> pending == (s_q.prev ~^ $past(polarity)))
      else $error("level pending does not track input");
   a_edge_sets: assert property (@(posedge clk) disable iff (!rst_b)
      (trigger_type && $stable(trigger_type) && $stable(polarity) && rise)
      |=> pending)
      else $error("edge did not set pending");
   a_vector_clears: assert property (@(posedge clk) disable iff (!rst_b)
      (trigger_type && $stable(trigger_type) && vector_ack && !rise) |=> !pending)
      else $error("vectoring did not clear pending");
endmodule

/* verilog/ext_irq_sources.sv */
/*
 Two external pin interrupt sources with their pin configuration register and
 the trigger-type and pending bits of the timer control register.
 Assumes a single-cycle SFR port; the core pulses vector acknowledges.
*/
`timescale 1ns/1ps
module ext_irq_sources #(
   parameter int pins = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [pins-1:0] port_pins,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic timer_control_register_write,
   input wire logic [3:0] timer_control_register_wdata,
   input wire logic vector_a,
   input wire logic vector_b,
   output logic [7:0] sfr_rdata,
   output logic [3:0] timer_control_register_rdata,
   output logic irq_a_pending,
   output logic irq_b_pending
);
   typedef struct packed {
      logic [7:0] cfg;
      logic irq_a_trigger_type;
      logic irq_b_trigger_type;
      logic [7:0] rdata;
      logic [3:0] timer_control_register;
      logic a_pend;
      logic b_pend;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;
   logic a_pend_w;
   logic b_pend_w;
   logic cfg_hit;

   // Pin select field of one channel within the configuration byte
   function automatic logic [2:0] select_field(input logic [7:0] cfg, input int lsb);
      select_field = cfg[lsb +: 3];
   endfunction

   // Polarity bit of one channel within the configuration byte
   function automatic logic polarity_field(input logic [7:0] cfg, input int pos);
      polarity_field = cfg[pos];
   endfunction

   // Channel a: pin select in the low nibble of the configuration byte
   ext_irq_channel #(.pins(pins)) u_chan_a (
      .clk(clk),
      .rst_b(rst_b),
      .port_pins(port_pins),
      .pin_select(select_field(s_q.cfg, ext_irq_pkg::a_select_lsb)),
      .polarity(polarity_field(s_q.cfg, ext_irq_pkg::a_polarity_bit)),
      .trigger_type(s_q.irq_a_trigger_type),
      .vector_ack(vector_a),
      .flag_write(timer_control_register_write),
      .flag_value(timer_control_register_wdata[ext_irq_pkg::a_pending_bit]),
      .pending(a_pend_w)
   );

   // Channel b: pin select in the high nibble of the configuration byte
   ext_irq_channel #(.pins(pins)) u_chan_b (
      .clk(clk),
      .rst_b(rst_b),
      .port_pins(port_pins),
      .pin_select(select_field(s_q.cfg, ext_irq_pkg::b_select_lsb)),
      .polarity(polarity_field(s_q.cfg, ext_irq_pkg::b_polarity_bit)),
      .trigger_type(s_q.irq_b_trigger_type),
      .vector_ack(vector_b),
      .flag_write(timer_control_register_write),
      .flag_value(timer_control_register_wdata[ext_irq_pkg::b_pending_bit]),
      .pending(b_pend_w)
   );

   always_comb
   begin
      s_d = s_q;
      cfg_hit = (sfr_addr == ext_irq_pkg::pin_config_addr);
      if (sfr_write && cfg_hit)
         s_d.cfg = sfr_wdata;
      if (timer_control_register_write)
      begin
         s_d.irq_a_trigger_type = timer_control_register_wdata[ext_irq_pkg::a_trigger_bit];
         s_d.irq_b_trigger_type = timer_control_register_wdata[ext_irq_pkg::b_trigger_bit];
      end
      if (sfr_read)
         s_d.rdata = cfg_hit ? s_q.cfg : 8'h00;
      s_d.timer_control_register = {b_pend_w, s_q.irq_b_trigger_type, a_pend_w, s_q.irq_a_trigger_type};
      s_d.a_pend = a_pend_w;
      s_d.b_pend = b_pend_w;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.cfg <= ext_irq_pkg::pin_config_reset;
      end
      else
         s_q <= s_d;
   end

   assign sfr_rdata = s_q.rdata;
   assign timer_control_register_rdata = s_q.timer_control_register;
   assign irq_a_pending = s_q.a_pend;
   assign irq_b_pending = s_q.b_pend;


   // A decoded write lands in the configuration byte one cycle later
   a_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
      (sfr_write && sfr_addr == ext_irq_pkg::pin_config_addr) |=> s_q.cfg == $past(sfr_wdata))
      else $error("config write not stored");

   // Without a decoded write the configuration byte keeps its value
   a_cfg_holds: assert property (@(posedge clk) disable iff (!rst_b)
      !(sfr_write && sfr_addr == ext_irq_pkg::pin_config_addr) |=> $stable(s_q.cfg))
      else $error("config changed without a write");

   // A decoded read returns the configuration byte
   a_cfg_read: assert property (@(posedge clk) disable iff (!rst_b)
      (sfr_read && sfr_addr == ext_irq_pkg::pin_config_addr) |=> sfr_rdata == $past(s_q.cfg))
      else $error("config read data wrong");

   // Read data stands until the next read strobe
   a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_b)
      !sfr_read |=> $stable(sfr_rdata))
      else $error("read data changed without a read");

   // Pending flags sit at control bits 1 and 3
   a_timer_control_register_map: assert property (@(posedge clk) disable iff (!rst_b)
      timer_control_register_rdata[ext_irq_pkg::a_pending_bit] == irq_a_pending &&
      timer_control_register_rdata[ext_irq_pkg::b_pending_bit] == irq_b_pending)
      else $error("pending bits misplaced in control register");

   // Trigger-type bits sit at control bits 0 and 2
   a_trig_bits_map: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> timer_control_register_rdata[ext_irq_pkg::a_trigger_bit] == $past(s_q.irq_a_trigger_type) &&
      timer_control_register_rdata[ext_irq_pkg::b_trigger_bit] == $past(s_q.irq_b_trigger_type))
      else $error("trigger bits misplaced in control register");

   // Control write stores the trigger type of channel b
   a_trig_write: assert property (@(posedge clk) disable iff (!rst_b)
      timer_control_register_write |=> s_q.irq_b_trigger_type == $past(timer_control_register_wdata[ext_irq_pkg::b_trigger_bit]))
      else $error("trigger type not stored");

   // Control write stores the trigger type of channel a
   a_trig_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      timer_control_register_write |=> s_q.irq_a_trigger_type == $past(timer_control_register_wdata[ext_irq_pkg::a_trigger_bit]))
      else $error("trigger type a not stored");

   // Trigger types change only on a control write
   a_trig_holds: assert property (@(posedge clk) disable iff (!rst_b)
      !timer_control_register_write |=> $stable(s_q.irq_a_trigger_type) && $stable(s_q.irq_b_trigger_type))
      else $error("trigger type changed without a write");

   // Reads of other addresses return zero
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (sfr_read && sfr_addr != ext_irq_pkg::pin_config_addr) |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");

   // Pending outputs are the channel flags, one cycle later
   a_pend_follows: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> irq_a_pending == $past(a_pend_w))
      else $error("pending output not registered from channel");

   a_b_pend_follows: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> irq_b_pending == $past(b_pend_w))
      else $error("pending output b not registered from channel");
endmodule

/* bench/pin_driver.sv */
/*
 External source model: drives the port-0 pin levels that the bench asks for.
 Assumes the bench keeps a level request up until its pending flag has been seen.
*/
`timescale 1ns/1ps
module pin_driver (
   input wire logic clk,
   input wire logic [7:0] want,
   output logic [7:0] port_pins
);
   // Pin levels follow the bench request, registered one clock later
   always_ff @(posedge clk)
   begin
      port_pins <= want;
   end
endmodule

/* bench/testbench.sv */
/*
 Self-checking bench for the two external pin interrupt sources.
 Assumes the pin_driver model and the ext_irq_sources top module.
*/
`timescale 1ns/1ps
`define chk(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, sfr_write = 1'b0, sfr_read = 1'b0;
   logic timer_control_register_write = 1'b0, vector_a = 1'b0, vector_b = 1'b0;
   logic irq_a_pending, irq_b_pending;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, want = 8'hff, port_pins;
   logic [3:0] timer_control_register_wdata = 4'h0, timer_control_register_rdata;
   localparam logic [7:0] cfg = ext_irq_pkg::pin_config_addr;
   int fails = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   pin_driver u_pin_driver (.clk(clk), .want(want), .port_pins(port_pins));
   ext_irq_sources u_ext_irq_sources (.clk(clk), .rst_b(rst_b), .port_pins(port_pins),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
      .sfr_read(sfr_read), .timer_control_register_write(timer_control_register_write), .timer_control_register_wdata(timer_control_register_wdata),
      .vector_a(vector_a), .vector_b(vector_b), .sfr_rdata(sfr_rdata),
      .timer_control_register_rdata(timer_control_register_rdata), .irq_a_pending(irq_a_pending),
      .irq_b_pending(irq_b_pending));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] d);
      sfr_addr = cfg;
      sfr_wdata = d;
      sfr_write = 1'b1;
      step(1);
      sfr_write = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      sfr_read = 1'b1;
      step(1);
      sfr_read = 1'b0;
      `chk(sfr_rdata, e)
   endtask
   task automatic tc(input logic [3:0] d);
      timer_control_register_wdata = d;
      timer_control_register_write = 1'b1;
      step(1);
      timer_control_register_write = 1'b0;
   endtask
   task automatic print_verdict;
      $display("fails=%0d checks_done=%0d", fails, checks_done);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      step(4);
      rst_b = 1'b1;
      `chk(timer_control_register_rdata, 4'h0)
      rd(cfg, ext_irq_pkg::pin_config_reset);
      rd(8'he5, 8'h00);
      `chk(irq_a_pending, 1'b0)
      wr(8'h35);
      rd(cfg, 8'h35);
      want[5] = 1'b0;
      step(6);
      `chk(irq_a_pending, 1'b1)
      want[5] = 1'b1;
      step(6);
      `chk(irq_a_pending, 1'b0)
      tc(4'h5);
      want[5] = 1'b0;
      step(6);
      `chk(irq_a_pending, 1'b1)
      vector_a = 1'b1;
      step(1);
      vector_a = 1'b0;
      step(2);
      `chk(irq_a_pending, 1'b0)
      want[5] = 1'b1;
      want[3] = 1'b0;
      step(6);
      `chk(timer_control_register_rdata, 4'hd)
      vector_b = 1'b1;
      step(1);
      vector_b = 1'b0;
      step(2);
      `chk(irq_b_pending, 1'b0)
      tc(4'hf);
      step(2);
      `chk(timer_control_register_rdata, 4'hf)
      tc(4'h5);
      step(2);
      `chk(timer_control_register_rdata, 4'h5)
      tc(4'h0);
      want = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         wr({1'b1, 3'(i), 4'h8});
         want = 8'h01 << i;
         step(6);
         `chk(irq_b_pending, 1'b1)
         want = 8'h00;
         step(6);
         `chk(irq_b_pending, 1'b0)
      end
      print_verdict;
   end
   initial
   begin
      #20000;
      fails++;
      print_verdict;
   end
endmodule
